// *** inc/fpl_pkg.sv ***
// Shared constants and carrier types for the front-panel status LED logic
package fpl_pkg;

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_PERIOD_NS = 1000000;
	localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLOW_BLINK_MS = 600;
	localparam int LAMP_TEST_MS = 500;
	localparam int FAULT_HOLD_MS = 5000;
	localparam int CNT_W = 20;
	localparam int MS_W = 13;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FIELD = 8'h04;
	localparam logic [7:0] REG_REDUN = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FIELD_RST = 32'h0000_0000;
	localparam logic [31:0] REDUN_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
	localparam logic [31:0] FIELD_MASK = 32'h0000_03FF;
	localparam logic [31:0] REDUN_MASK = 32'h0000_007F;

	// Control fields
	localparam int CTRL_LAMP_BIT = 0;
	localparam int CTRL_IPCONF_BIT = 1;
	// Fieldbus fields: two bits each, one per port
	localparam int FIELD_FITTED_LSB = 0;
	localparam int FIELD_OPER_LSB = 2;
	localparam int FIELD_FAULT_LSB = 4;
	localparam int FIELD_PROTO1_LSB = 6;
	localparam int FIELD_PROTO2_LSB = 8;
	localparam logic [1:0] PROTO_NONE = 2'h0;
	// Redundancy fields
	localparam int REDUN_CFG_LSB = 0;
	localparam int REDUN_RUN_LSB = 2;
	localparam int REDUN_PARTNER_LSB = 4;
	localparam int REDUN_SYNC_BIT = 6;
	// Status fields
	localparam int STAT_LAMP_BIT = 17;
	localparam int STAT_HOLD_BIT = 18;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] link;
		logic [3:0] act;
		logic [3:0] full;
		logic [3:0] col;
	} fpl_eth_pins_t;

	typedef struct packed {
		logic [1:0] phys;
		logic [1:0] logic_ok;
	} fpl_sys_pins_t;

	typedef struct packed {
		logic ess;
		logic redun;
		logic sys_a_grn;
		logic sys_a_yel;
		logic sys_b_grn;
		logic sys_b_yel;
		logic field_port_one;
		logic field_port_two;
		logic fb_fault;
		logic [3:0] eth_grn;
		logic [3:0] eth_yel;
	} fpl_led_t;

	localparam int PIN_W = 20;

endpackage

// *** logic/fpl_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module fpl_sync #(
	parameter int WIDTH = 20
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [WIDTH-1:0] D,
	output logic [WIDTH-1:0] Q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} fpl_sync_state_t;

	fpl_sync_state_t s;
	fpl_sync_state_t next_s;

	// Stage one feeds stage two only; a bit moves once stages two and three agree
	always_comb begin
		next_s = s;
		next_s.s1 = D;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.q = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign Q = s.q;

endmodule

// *** logic/fpl_leds.sv ***
// Front-panel status LED logic with classic Wishbone register slave
//
// How it works
// - Single-protocol LED on for non-redundant protocol
// - Single-protocol LED blinks if redundancy degraded
// - Single-protocol LED dark when all redundant
// - Redundancy LED on when all run redundantly
// - Redundancy LED blinks on sync or missing partner
// - Redundancy LED dark without redundant protocols
// - Bus LED green on with full connection
// - Bus LED blinks green without physical link
// - Bus LED blinks yellow without processor reach
// - Both bus LEDs dark when nothing connected
// - Fieldbus LED yellow while operating, else dark
// - Fault LED blinks, held at least 5 s
// - Green port LED on, follows traffic when active
// - Green port LED dark without partner
// - IP conflict makes all Ethernet LEDs blink
// - Yellow port LED shows full versus half duplex
// - Yellow port LED follows traffic on collisions
// - No submodule fitted keeps fieldbus LED dark
// - One protocol code per fieldbus port
// - Slow blink is 600 ms on, 600 off
// - Traffic blink follows data transfer itself
// - Lamp test lights all LEDs after reset
`timescale 1ns/1ns
module fpl_leds #(
	parameter int MS_CYCLES = fpl_pkg::MS_CYCLES,
	parameter int FAULT_HOLD_MS = fpl_pkg::FAULT_HOLD_MS
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire fpl_pkg::fpl_eth_pins_t ETH_PINS,
	input wire fpl_pkg::fpl_sys_pins_t SYS_PINS,
	output fpl_pkg::fpl_led_t LEDS
);

	// ----------------------------------------
	// Local constants
	// ----------------------------------------
	localparam logic [fpl_pkg::CNT_W-1:0] TICK_LAST = fpl_pkg::CNT_W'(MS_CYCLES - 1);
	localparam logic [fpl_pkg::MS_W-1:0] BLINK_LAST =
		fpl_pkg::MS_W'(fpl_pkg::SLOW_BLINK_MS - 1);
	localparam logic [fpl_pkg::MS_W-1:0] LAMP_LOAD = fpl_pkg::MS_W'(fpl_pkg::LAMP_TEST_MS);
	localparam logic [fpl_pkg::MS_W-1:0] HOLD_LOAD = fpl_pkg::MS_W'(FAULT_HOLD_MS);

	typedef struct packed {
		logic [fpl_pkg::CNT_W-1:0] tick_cnt;
		logic ms_tick;
		logic [fpl_pkg::MS_W-1:0] blink_cnt;
		logic blink;
		logic [fpl_pkg::MS_W-1:0] lamp_cnt;
		logic [fpl_pkg::MS_W-1:0] hold_cnt;
		logic [31:0] ctrl;
		logic [31:0] field;
		logic [31:0] redun;
		logic ack;
		logic [31:0] dat;
		fpl_pkg::fpl_led_t leds;
	} fpl_state_t;

	fpl_state_t s;
	fpl_state_t next_s;
	logic [fpl_pkg::PIN_W-1:0] pins_sync;
	fpl_pkg::fpl_eth_pins_t eth;
	fpl_pkg::fpl_sys_pins_t sys;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Address match, shared by the write and read paths
	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		reg_hit = (adr == off);
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		merge_sel = res & mask;
	endfunction

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	fpl_sync #(
		.WIDTH(fpl_pkg::PIN_W)
	) u_sync (
		.CLOCK(CLOCK),
		.RST(RST),
		.D({ETH_PINS, SYS_PINS}),
		.Q(pins_sync)
	);

	assign eth = fpl_pkg::fpl_eth_pins_t'(pins_sync[fpl_pkg::PIN_W-1:4]);
	assign sys = fpl_pkg::fpl_sys_pins_t'(pins_sync[3:0]);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [1:0] fitted;
		logic [1:0] oper;
		logic [1:0] fault;
		logic [1:0] active;
		logic [1:0] cfg_red;
		logic [1:0] run_red;
		logic [1:0] partner;
		logic sync_busy;
		logic [1:0] red_used;
		logic [1:0] non_red;
		logic [1:0] degraded;
		logic no_sys;
		logic ipconf;
		logic lamp;
		fitted = '0;
		oper = '0;
		fault = '0;
		active = '0;
		cfg_red = '0;
		run_red = '0;
		partner = '0;
		sync_busy = 1'b0;
		red_used = '0;
		non_red = '0;
		degraded = '0;
		no_sys = 1'b0;
		ipconf = 1'b0;
		lamp = 1'b0;
		next_s = s;

		// Millisecond tick divided from the system clock
		if (s.tick_cnt >= TICK_LAST) begin
			next_s.tick_cnt = '0;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 1'b1;
			next_s.ms_tick = 1'b0;
		end

		// Slow blink: phase flips every 600 ticks, so on and off are equal
		if (s.ms_tick) begin
			if (s.blink_cnt >= BLINK_LAST) begin
				next_s.blink_cnt = '0;
				next_s.blink = ~s.blink;
			end else begin
				next_s.blink_cnt = s.blink_cnt + 1'b1;
			end
		end

		// Lamp test counts down from reset release
		if (s.ms_tick && (s.lamp_cnt != '0)) begin
			next_s.lamp_cnt = s.lamp_cnt - 1'b1;
		end

		// Decode software-written status words
		fitted = s.field[fpl_pkg::FIELD_FITTED_LSB +: 2];
		oper = s.field[fpl_pkg::FIELD_OPER_LSB +: 2];
		fault = s.field[fpl_pkg::FIELD_FAULT_LSB +: 2];
		// A port holds a single protocol code, so it can never carry two
		active[0] = fitted[0] &&
			(s.field[fpl_pkg::FIELD_PROTO1_LSB +: 2] != fpl_pkg::PROTO_NONE);
		active[1] = fitted[1] &&
			(s.field[fpl_pkg::FIELD_PROTO2_LSB +: 2] != fpl_pkg::PROTO_NONE);
		cfg_red = s.redun[fpl_pkg::REDUN_CFG_LSB +: 2];
		run_red = s.redun[fpl_pkg::REDUN_RUN_LSB +: 2];
		partner = s.redun[fpl_pkg::REDUN_PARTNER_LSB +: 2];
		sync_busy = s.redun[fpl_pkg::REDUN_SYNC_BIT];
		red_used = active & cfg_red;
		non_red = active & ~cfg_red;
		degraded = red_used & ~run_red;
		ipconf = s.ctrl[fpl_pkg::CTRL_IPCONF_BIT];

		// Fault hold: reload while a fault stands, run down afterwards
		if (fault != '0) begin
			next_s.hold_cnt = HOLD_LOAD;
		end else if (s.ms_tick && (s.hold_cnt != '0)) begin
			next_s.hold_cnt = s.hold_cnt - 1'b1;
		end

		// Single-protocol redundancy LED; steady on takes priority
		if (non_red != '0) begin
			next_s.leds.ess = 1'b1;
		end else if (degraded != '0) begin
			next_s.leds.ess = s.blink;
		end else begin
			next_s.leds.ess = 1'b0;
		end

		// Redundancy LED
		if (red_used == '0) begin
			next_s.leds.redun = 1'b0;
		end else if (sync_busy || ((red_used & ~partner) != '0) || (degraded != '0)) begin
			next_s.leds.redun = s.blink;
		end else begin
			next_s.leds.redun = 1'b1;
		end

		// System bus LEDs, one pair per slot
		no_sys = (sys.phys == '0) && (sys.logic_ok == '0);
		next_s.leds.sys_a_grn = 1'b0;
		next_s.leds.sys_a_yel = 1'b0;
		next_s.leds.sys_b_grn = 1'b0;
		next_s.leds.sys_b_yel = 1'b0;
		if (!no_sys) begin
			if (sys.phys[0] && sys.logic_ok[0]) begin
				next_s.leds.sys_a_grn = 1'b1;
			end else if (!sys.phys[0]) begin
				next_s.leds.sys_a_grn = s.blink;
			end else begin
				next_s.leds.sys_a_yel = s.blink;
			end
			if (sys.phys[1] && sys.logic_ok[1]) begin
				next_s.leds.sys_b_grn = 1'b1;
			end else if (!sys.phys[1]) begin
				next_s.leds.sys_b_grn = s.blink;
			end else begin
				next_s.leds.sys_b_yel = s.blink;
			end
		end

		// Fieldbus activity needs a fitted submodule and a protocol
		next_s.leds.field_port_one = oper[0] && active[0];
		next_s.leds.field_port_two = oper[1] && active[1];
		next_s.leds.fb_fault = ((fault != '0) || (s.hold_cnt != '0)) && s.blink;

		// Ethernet ports; activity level gates the LED so it flickers with frames
		for (int p = 0; p < 4; p++) begin
			if (ipconf) begin
				next_s.leds.eth_grn[p] = s.blink;
				next_s.leds.eth_yel[p] = s.blink;
			end else begin
				next_s.leds.eth_grn[p] = eth.link[p] && !eth.act[p];
				if (eth.col[p]) begin
					next_s.leds.eth_yel[p] = !eth.act[p];
				end else begin
					next_s.leds.eth_yel[p] = eth.full[p];
				end
			end
		end

		// Lamp test overrides everything while it runs
		lamp = (s.lamp_cnt != '0) || s.ctrl[fpl_pkg::CTRL_LAMP_BIT];
		if (lamp) begin
			next_s.leds = '1;
		end

		// Wishbone classic slave: one wait state, ack for one cycle
		next_s.ack = 1'b0;
		if (WB_CYC_I && WB_STB_I && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.dat = '0;
			if (WB_WE_I) begin
				if (reg_hit(WB_ADR_I, fpl_pkg::REG_CTRL)) begin
					next_s.ctrl = merge_sel(s.ctrl, WB_DAT_I, WB_SEL_I, fpl_pkg::CTRL_MASK);
				end else if (reg_hit(WB_ADR_I, fpl_pkg::REG_FIELD)) begin
					next_s.field = merge_sel(s.field, WB_DAT_I, WB_SEL_I, fpl_pkg::FIELD_MASK);
				end else if (reg_hit(WB_ADR_I, fpl_pkg::REG_REDUN)) begin
					next_s.redun = merge_sel(s.redun, WB_DAT_I, WB_SEL_I, fpl_pkg::REDUN_MASK);
				end
			end else begin
				if (reg_hit(WB_ADR_I, fpl_pkg::REG_CTRL)) begin
					next_s.dat = s.ctrl;
				end else if (reg_hit(WB_ADR_I, fpl_pkg::REG_FIELD)) begin
					next_s.dat = s.field;
				end else if (reg_hit(WB_ADR_I, fpl_pkg::REG_REDUN)) begin
					next_s.dat = s.redun;
				end else if (reg_hit(WB_ADR_I, fpl_pkg::REG_STATUS)) begin
					next_s.dat[16:0] = s.leds;
					next_s.dat[fpl_pkg::STAT_LAMP_BIT] = lamp;
					next_s.dat[fpl_pkg::STAT_HOLD_BIT] = (s.hold_cnt != '0);
				end
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset lights nothing; the lamp counter starts full so the test runs at once
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			s <= '0;
			s.lamp_cnt <= LAMP_LOAD;
			s.ctrl <= fpl_pkg::CTRL_RST;
			s.field <= fpl_pkg::FIELD_RST;
			s.redun <= fpl_pkg::REDUN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign WB_DAT_O = s.dat;
	assign WB_ACK_O = s.ack;
	assign LEDS = s.leds;

endmodule

// *** verification/fpl_leds_properties.sv ***
// Port-level property checker for the front-panel LED block
`timescale 1ns/1ns
module fpl_chk #(
	parameter int MS_CYCLES = 10,
	parameter int FAULT_HOLD_MS = 20
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic WB_ACK_O,
	input wire fpl_pkg::fpl_eth_pins_t ETH_PINS,
	input wire fpl_pkg::fpl_sys_pins_t SYS_PINS,
	input wire fpl_pkg::fpl_led_t LEDS
);
	logic [1:0] ctrl;
	logic [3:0] calm;
	int lamp;
	logic q;
	logic wr;
	assign wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	assign q = calm == 4'hF && lamp == 0;
	// Control shadow and settle count; pins take a few cycles through the synchroniser
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctrl <= 2'h0;
			calm <= 4'h0;
			lamp <= fpl_pkg::LAMP_TEST_MS * MS_CYCLES + 4;
		end else begin
			lamp <= lamp > 0 ? lamp - 1 : 0;
			calm <= calm == 4'hF ? calm : calm + 4'h1;
			if ($changed(ETH_PINS) || $changed(SYS_PINS))
				calm <= 4'h0;
			if (wr && WB_ADR_I == fpl_pkg::REG_CTRL) begin
				ctrl <= WB_DAT_I[1:0];
				calm <= 4'h0;
			end
		end
	end
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	chk_lamp_start:
		assert property ($fell(RST) |=> (&LEDS) [*8]) else $error("lamp test missing");
	chk_lamp_force:
		assert property (q && ctrl[0] |-> &LEDS) else $error("forced lamp test missing");
	chk_eth_follow:
		assert property (q && ctrl == 2'h0 |-> LEDS.eth_grn == (ETH_PINS.link & ~ETH_PINS.act)
			&& LEDS.eth_yel == (ETH_PINS.col & ~ETH_PINS.act | ~ETH_PINS.col & ETH_PINS.full))
		else $error("port LEDs wrong");
	chk_ip_blink:
		assert property (q && ctrl == 2'h2 |-> LEDS.eth_grn == {4{LEDS.eth_yel[0]}}
			&& LEDS.eth_yel == {4{LEDS.eth_yel[0]}}) else $error("port LEDs not in unison");
	chk_sys_dark:
		assert property (q && !ctrl[0] && SYS_PINS == 4'h0 |-> LEDS[14:11] == 4'h0)
		else $error("bus LEDs not dark");
	chk_sys_green:
		assert property (q && !ctrl[0] && SYS_PINS.phys[1] && SYS_PINS.logic_ok[1]
			|-> LEDS.sys_b_grn && !LEDS.sys_b_yel) else $error("bus LED not green");
	chk_sys_excl:
		assert property (LEDS.sys_a_grn && LEDS.sys_a_yel |-> &LEDS) else $error("bus LED mixed");
	chk_ack_taken:
		assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
	chk_ack_pulse:
		assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	cover property (q && ctrl == 2'h2 && LEDS.eth_grn[0]);
	cover property (q && LEDS.sys_a_yel);
	cover property ($fell(LEDS.fb_fault));
endmodule

bind fpl_leds fpl_chk #(.MS_CYCLES(MS_CYCLES), .FAULT_HOLD_MS(FAULT_HOLD_MS)) chk (
	.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
	.ETH_PINS(ETH_PINS), .SYS_PINS(SYS_PINS), .LEDS(LEDS));

// *** verification/fpl_src.sv ***
// Model of the status sources: port link, duplex, collision, traffic and slot state
`timescale 1ns/1ns
module fpl_src (
	input wire logic CLOCK,
	input wire logic [3:0] link,
	input wire logic [3:0] full,
	input wire logic [3:0] col,
	input wire logic [3:0] busy,
	input wire logic [3:0] slots,
	output fpl_pkg::fpl_eth_pins_t eth,
	output fpl_pkg::fpl_sys_pins_t sys
);
	logic [3:0] beat = 4'h0;
	// Frames come in bursts, so activity flickers only on linked ports with traffic
	always @(posedge CLOCK) begin
		beat <= beat + 4'h1;
	end
	assign eth = {link, link & busy & {4{beat[3]}}, full, col};
	assign sys = slots;
endmodule

// *** verification/test_fpl_leds.sv ***
// Self-checking bench for the front-panel LED block
`timescale 1ns/1ns
module test_fpl_leds;
	localparam int BL = fpl_pkg::SLOW_BLINK_MS * 10;
	typedef struct packed {
		logic [1:0] ctrl;
		logic [9:0] field;
		logic [6:0] redun;
		logic [3:0] sys, link, full, col;
		logic [16:0] on, blk;
	} fpl_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd, rdat;
	logic [3:0] link = 4'h0, full = 4'h0, col = 4'h0, busy = 4'h0, slots = 4'h0;
	logic ack;
	fpl_pkg::fpl_eth_pins_t eth;
	fpl_pkg::fpl_sys_pins_t sysp;
	fpl_pkg::fpl_led_t leds;
	int tcnt = 0;
	int bad_count = 0;
	int checks_done = 0;
	int n, k;
	logic [31:0] masks [3] = '{fpl_pkg::CTRL_MASK, fpl_pkg::FIELD_MASK, fpl_pkg::REDUN_MASK};
	// Ordinary cases: registers and pins beside the steady and blinking LEDs they give
	fpl_row_t rows [9] = '{
		'{2'h0, 10'h000, 7'h00, 4'h0, 4'h0, 4'h0, 4'h0, 17'h00000, 17'h00000},
		'{2'h0, 10'h047, 7'h00, 4'hF, 4'hF, 4'h5, 4'h0, 17'h154F5, 17'h00000},
		'{2'h0, 10'h010, 7'h00, 4'h4, 4'h3, 4'h0, 4'h2, 17'h00032, 17'h03100},
		'{2'h0, 10'h24F, 7'h3F, 4'hA, 4'h0, 4'hF, 4'h0, 17'h0960F, 17'h04000},
		'{2'h0, 10'h24F, 7'h37, 4'h0, 4'h0, 4'h0, 4'h0, 17'h00600, 17'h18000},
		'{2'h0, 10'h24F, 7'h7F, 4'h0, 4'h0, 4'h0, 4'h0, 17'h00600, 17'h08000},
		'{2'h2, 10'h000, 7'h00, 4'h0, 4'hF, 4'h0, 4'h0, 17'h00000, 17'h000FF},
		'{2'h1, 10'h000, 7'h00, 4'h0, 4'h0, 4'h0, 4'h0, 17'h1FFFF, 17'h00000},
		'{2'h0, 10'h14C, 7'h00, 4'h0, 4'h0, 4'h0, 4'h0, 17'h00000, 17'h00000}};
	fpl_src partner (.CLOCK(clk), .link(link), .full(full), .col(col), .busy(busy),
		.slots(slots), .eth(eth), .sys(sysp));
	fpl_leds #(.MS_CYCLES(10), .FAULT_HOLD_MS(20)) uut (.CLOCK(clk), .RST(rst), .WB_CYC_I(cyc),
		.WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .ETH_PINS(eth), .SYS_PINS(sysp), .LEDS(leds));
	// 125 MHz clock and a cycle count since reset that gives the blink phase
	always #4 clk = ~clk;
	always @(posedge clk) begin
		tcnt <= rst ? 0 : tcnt + 1;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic conclude();
		$display("Checks %0d, errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic cycle; the request stands until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int m;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		m = 0;
		do begin
			@(posedge clk);
			m++;
		end while (ack !== 1'b1 && m < 20);
		rd = rdat;
		cyc <= 1'b0;
		if (m == 20) begin
			bad_count++;
			conclude();
		end
	endtask
	// Waits for a spot in the blink period, away from the toggle instants
	task automatic settle(input int lo, input int hi, input int ph);
		int m;
		m = 0;
		while (!(tcnt % BL >= lo && tcnt % BL <= hi && (ph > 1 || tcnt / BL % 2 == ph))
			&& m < 30000) begin
			@(posedge clk);
			m++;
		end
		if (m == 30000) begin
			bad_count++;
			conclude();
		end
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, fpl_pkg::REG_STATUS, 4'hF, 32'h0);
		check(rd, 32'h0003FFFF);
		wb(1'b0, 8'h10, 4'hF, 32'h0);
		check(rd, 32'h0);
		for (k = 0; k < 3; k++) begin
			wb(1'b0, 8'(4 * k), 4'hF, 32'h0);
			check(rd, 32'h0);
			wb(1'b1, 8'(4 * k), 4'hF, 32'hFFFFFFFF);
			wb(1'b1, 8'(4 * k), 4'h0, 32'h0);
			wb(1'b0, 8'(4 * k), 4'hF, 32'h0);
			check(rd, masks[k]);
			wb(1'b1, 8'(4 * k), 4'hF, 32'h0);
		end
		repeat (5100) @(posedge clk);
		for (k = 0; k < 9; k++) begin
			wb(1'b1, fpl_pkg::REG_CTRL, 4'hF, 32'(rows[k].ctrl));
			wb(1'b1, fpl_pkg::REG_FIELD, 4'hF, 32'(rows[k].field));
			wb(1'b1, fpl_pkg::REG_REDUN, 4'hF, 32'(rows[k].redun));
			slots <= rows[k].sys;
			link <= rows[k].link;
			full <= rows[k].full;
			col <= rows[k].col;
			repeat (300) @(posedge clk);
			settle(50, BL - 50, 2);
			rd = 32'(rows[k].on | (rows[k].blk & {17{tcnt / BL % 2 == 1}}));
			check(32'(leds), rd);
		end
		wb(1'b1, fpl_pkg::REG_CTRL, 4'hF, 32'h0);
		link <= 4'h1;
		col <= 4'h1;
		busy <= 4'h1;
		repeat (20) @(posedge clk);
		n = 0;
		for (k = 0; k < 64; k++) begin
			@(posedge clk);
			n += int'(leds.eth_grn[0]) + int'(leds.eth_yel[0]);
		end
		check(32'(n >= 48 && n <= 80), 32'h1);
		busy <= 4'h0;
		repeat (20) @(posedge clk);
		check(32'(leds.eth_grn[0]), 32'h1);
		settle(50, 5000, 1);
		wb(1'b1, fpl_pkg::REG_FIELD, 4'hF, 32'h10);
		wb(1'b1, fpl_pkg::REG_FIELD, 4'hF, 32'h0);
		repeat (150) @(posedge clk);
		check(32'(leds.fb_fault), 32'h1);
		repeat (120) @(posedge clk);
		check(32'(leds.fb_fault), 32'h0);
		wb(1'b1, fpl_pkg::REG_CTRL, 4'hF, 32'h2);
		settle(50, 100, 0);
		// Bounded wait for the lit phase; running out counts as a mismatch
		n = 0;
		while (leds.eth_grn[0] !== 1'b1 && n < 2 * BL) begin
			@(posedge clk);
			n++;
		end
		check(32'(n < 2 * BL), 32'h1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (leds.eth_grn[0] === 1'b1 && n < 2 * BL);
		check(32'(n), 32'(BL));
		conclude();
	end
endmodule
